// ==== logic/address_gpio_ports_one_two.sv ====
// Purpose: ports one and two: direction, output latch, pull-up control, pin muxing
// Assumes: bus address and software standby come from the core clock domain
// Notes: mode straps and hardware standby pin are synchronised before use
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`include "gpio_ports_defines.svh"
module address_gpio_ports_one_two (
	input  wire logic        i_core_clk,      // 100 MHz core clock
	input  wire logic        i_resetn,        // async reset, active low
	input  wire logic [2:0]  i_mode,          // operating mode straps
	input  wire logic        i_hw_standby_n,  // hardware standby pin, active low
	input  wire logic        i_sw_standby,    // software standby level
	input  wire logic [15:0] i_ext_addr,      // external bus address
	input  wire logic [15:0] i_reg_addr,      // register address
	input  wire logic [7:0]  i_reg_wdata,     // register write data
	input  wire logic        i_reg_wr,        // write strobe
	input  wire logic        i_reg_rd,        // read strobe
	output logic      [7:0]  o_reg_rdata,     // read data, cycle after strobe
	input  wire logic [7:0]  i_p1_pin,        // port one pin levels
	output logic      [7:0]  o_p1_out,        // port one drive level
	output logic      [7:0]  o_p1_oe,         // port one output enable
	input  wire logic [7:0]  i_p2_pin,        // port two pin levels
	output logic      [7:0]  o_p2_out,        // port two drive level
	output logic      [7:0]  o_p2_oe,         // port two output enable
	output logic      [7:0]  o_p2_pullup      // port two pull-up enable
);
	logic                       rst_meta;
	logic                       rst_n;
	logic [2:0]                 mode_sync;
	logic                       hw_standby_n_sync;
	logic                       hw_standby;
	logic                       strap_taken;
	logic [1:0]                 strap_wait;
	logic [2:0]                 mode;
	gpio_ports_pkg::pin_role_e  role;
	gpio_ports_pkg::reg_req_s   req;
	logic                       dir_writable;
	logic [7:0]                 port_one_direction;
	logic [7:0]                 port_two_direction;
	logic [7:0]                 port_one_output_latch;
	logic [7:0]                 port_two_output_latch;
	logic [7:0]                 port_two_pullup_enable;
	logic [7:0]                 p1_level;
	logic [7:0]                 p2_level;
	gpio_ports_pkg::pin_drive_s p1_drive;
	gpio_ports_pkg::pin_drive_s p2_drive;
	logic [7:0]                 next_rdata;
	logic [7:0]                 next_pullup;

	// reset released through two flops so every flop leaves reset on one edge
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	level_sync #(
		.WIDTH    (3),
		.RESET_VAL({5'h00, `MODE_RESET})
	) u_mode_sync (
		.i_clk  (i_core_clk),
		.i_rst_n(rst_n),
		.i_async(i_mode),
		.o_sync (mode_sync)
	);

	level_sync #(
		.WIDTH    (1),
		.RESET_VAL(8'h01)
	) u_standby_sync (
		.i_clk  (i_core_clk),
		.i_rst_n(rst_n),
		.i_async(i_hw_standby_n),
		.o_sync (hw_standby_n_sync)
	);

	assign hw_standby = !hw_standby_n_sync;

	// straps are caught once, after they have crossed both sync stages;
	// the sync flops leave reset holding the single-chip code, so wait them out
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_wait  <= 2'h0;
			strap_taken <= 1'b0;
			mode        <= `MODE_RESET;
		end else if (!strap_taken) begin
			if (strap_wait == `STRAP_SETTLE_CYCLES) begin
				strap_taken <= 1'b1;
				mode        <= mode_sync;
			end else begin
				strap_wait <= strap_wait + 2'h1;
			end
		end
	end

	// unlisted mode codes behave as single-chip
	always_comb begin
		case (mode)
			`MODE_ONE, `MODE_THREE: role = gpio_ports_pkg::ROLE_ADDRESS;
			`MODE_FIVE, `MODE_SIX:  role = gpio_ports_pkg::ROLE_MIXED;
			default:                role = gpio_ports_pkg::ROLE_GENERAL;
		endcase
	end

	always_comb begin
		req.addr  = i_reg_addr;
		req.wdata = i_reg_wdata;
		req.wr    = i_reg_wr;
		req.rd    = i_reg_rd;
	end

	// in address-only modes the direction registers are not software accessible
	assign dir_writable = (role != gpio_ports_pkg::ROLE_ADDRESS);

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_one_direction <= `DIRECTION_GENERAL_RESET;
			port_two_direction <= `DIRECTION_GENERAL_RESET;
		end else if (hw_standby || !strap_taken) begin
			port_one_direction <= `DIRECTION_GENERAL_RESET;
			port_two_direction <= `DIRECTION_GENERAL_RESET;
		end else if (!dir_writable) begin
			port_one_direction <= `DIRECTION_ADDRESS_RESET;
			port_two_direction <= `DIRECTION_ADDRESS_RESET;
		end else if (req.wr && !i_sw_standby) begin
			if (req.addr == `PORT_ONE_DIRECTION_OFFSET) begin
				port_one_direction <= req.wdata;
			end
			if (req.addr == `PORT_TWO_DIRECTION_OFFSET) begin
				port_two_direction <= req.wdata;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_one_output_latch <= `OUTPUT_LATCH_RESET;
			port_two_output_latch <= `OUTPUT_LATCH_RESET;
		end else if (hw_standby) begin
			port_one_output_latch <= `OUTPUT_LATCH_RESET;
			port_two_output_latch <= `OUTPUT_LATCH_RESET;
		end else if (req.wr && !i_sw_standby) begin
			if (req.addr == `PORT_ONE_OUTPUT_LATCH_OFFSET) begin
				port_one_output_latch <= req.wdata;
			end
			if (req.addr == `PORT_TWO_OUTPUT_LATCH_OFFSET) begin
				port_two_output_latch <= req.wdata;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_two_pullup_enable <= `PULLUP_ENABLE_RESET;
		end else if (hw_standby) begin
			port_two_pullup_enable <= `PULLUP_ENABLE_RESET;
		end else if (req.wr && !i_sw_standby
		             && req.addr == `PORT_TWO_PULLUP_ENABLE_OFFSET) begin
			port_two_pullup_enable <= req.wdata;
		end
	end

	// read data only in the cycle after the strobe, zero otherwise
	always_comb begin
		next_rdata = `UNMAPPED_READ_VALUE;
		if (req.rd) begin
			case (req.addr)
				`PORT_ONE_DIRECTION_OFFSET,
				`PORT_TWO_DIRECTION_OFFSET:     next_rdata = `DIRECTION_READ_VALUE;
				`PORT_ONE_OUTPUT_LATCH_OFFSET:  next_rdata =
					(port_one_direction & port_one_output_latch)
					| (~port_one_direction & p1_level);
				`PORT_TWO_OUTPUT_LATCH_OFFSET:  next_rdata =
					(port_two_direction & port_two_output_latch)
					| (~port_two_direction & p2_level);
				`PORT_TWO_PULLUP_ENABLE_OFFSET: next_rdata = port_two_pullup_enable;
				default:                        next_rdata = `UNMAPPED_READ_VALUE;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_reg_rdata <= `UNMAPPED_READ_VALUE;
		end else begin
			o_reg_rdata <= next_rdata;
		end
	end

	port_pin_slice u_port_one (
		.i_clk      (i_core_clk),
		.i_rst_n    (rst_n),
		.i_pin      (i_p1_pin),
		.i_direction(port_one_direction),
		.i_latch    (port_one_output_latch),
		.i_addr_byte(i_ext_addr[7:0]),
		.i_role     (role),
		.i_freeze   (i_sw_standby),
		.i_standby  (hw_standby),
		.o_level    (p1_level),
		.o_drive    (p1_drive)
	);

	port_pin_slice u_port_two (
		.i_clk      (i_core_clk),
		.i_rst_n    (rst_n),
		.i_pin      (i_p2_pin),
		.i_direction(port_two_direction),
		.i_latch    (port_two_output_latch),
		.i_addr_byte(i_ext_addr[15:8]),
		.i_role     (role),
		.i_freeze   (i_sw_standby),
		.i_standby  (hw_standby),
		.o_level    (p2_level),
		.o_drive    (p2_drive)
	);

	assign o_p1_out = p1_drive.level;
	assign o_p1_oe  = p1_drive.enable;
	assign o_p2_out = p2_drive.level;
	assign o_p2_oe  = p2_drive.enable;

	// pull-up only on an input pin outside the address-only modes
	always_comb begin
		next_pullup = 8'h00;
		if (role != gpio_ports_pkg::ROLE_ADDRESS) begin
			next_pullup = port_two_pullup_enable & ~port_two_direction;
		end
		if (i_sw_standby) begin
			next_pullup = o_p2_pullup;
		end
		if (hw_standby) begin
			next_pullup = 8'h00;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_p2_pullup <= 8'h00;
		end else begin
			o_p2_pullup <= next_pullup;
		end
	end
endmodule

// ==== logic/gpio_ports_defines.svh ====
// Purpose: offsets, reset values and mode codes for ports one and two
// Assumes: 16-bit register address, 8-bit register data
// Notes: included by bare name from the top module and the pin slice
// Functional notes
// - each port has an 8-bit write-only direction register, 1 means output
// - port one direction starts all ones in modes 1,3, zeros and writable in 5-7
// - port two direction starts all ones in modes 1,3, zeros and writable in 5-7
// - direction cleared by reset and hardware standby, kept in software standby
// - in software standby output pins keep driving their previous level
// - each port has an 8-bit read/write output latch starting at zero
// - reading a port returns the latch bit where direction is 1
// - reading a port returns the synchronised pin level where direction is 0
// - output latch cleared by reset and hardware standby, kept in software standby
// - in modes 1 and 3 every port one pin outputs address
// - in modes 5 and 6 direction 1 outputs address, 0 is general input
// - in modes 5 and 6 pins are inputs after reset; software sets direction first
// - in mode 7 direction 1 drives the latch bit, 0 is general input
// - in modes 1 and 3 port two carries address bits 15 to 8
// - port two: per-pin address or input in modes 5,6; general I/O in mode 7
// - port two has per-pin pull-ups switched by a control register
// - registers decoded at fixed addresses within the low 16 address bits
// - pull-up on only in modes 5-7 with control bit 1 and direction 0
// - pull-ups off in reset and hardware standby, held in software standby
// - reading a direction register returns all ones
`ifndef GPIO_PORTS_DEFINES_SVH
`define GPIO_PORTS_DEFINES_SVH

`define PORT_ONE_DIRECTION_OFFSET     16'hffc0
`define PORT_TWO_DIRECTION_OFFSET     16'hffc1
`define PORT_ONE_OUTPUT_LATCH_OFFSET  16'hffc2
`define PORT_TWO_OUTPUT_LATCH_OFFSET  16'hffc3
`define PORT_TWO_PULLUP_ENABLE_OFFSET 16'hffd8

`define DIRECTION_ADDRESS_RESET       8'hff
`define DIRECTION_GENERAL_RESET       8'h00
`define OUTPUT_LATCH_RESET            8'h00
`define PULLUP_ENABLE_RESET           8'h00
`define DIRECTION_READ_VALUE          8'hff
`define UNMAPPED_READ_VALUE           8'h00
`define PIN_LEVEL_RESET               8'h00

`define MODE_ONE                      3'h1
`define MODE_THREE                    3'h3
`define MODE_FIVE                     3'h5
`define MODE_SIX                      3'h6
`define MODE_SEVEN                    3'h7
`define MODE_RESET                    3'h7
`define STRAP_SETTLE_CYCLES           2'h2

`endif

// ==== logic/gpio_ports_pkg.sv ====
// Purpose: shared types for the port one/two block
// Assumes: constants live in gpio_ports_defines.svh
// Notes: no imports; users write gpio_ports_pkg::name
package gpio_ports_pkg;

	// which function the pins of a port have in the current mode
	typedef enum logic [2:0] {
		ROLE_ADDRESS = 3'b001,
		ROLE_MIXED   = 3'b010,
		ROLE_GENERAL = 3'b100
	} pin_role_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

	typedef struct packed {
		logic [7:0] level;
		logic [7:0] enable;
	} pin_drive_s;

endpackage

// ==== logic/level_sync.sv ====
// Purpose: two flip-flop synchroniser for levels from outside the clock domain
// Assumes: async active-low reset already released synchronously
// Notes: the first stage is read by the second stage only
`timescale 1ns/10ps
module level_sync #(
	parameter int         WIDTH     = 1,
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic             i_clk,   // core clock
	input  wire logic             i_rst_n, // synchronised reset, active low
	input  wire logic [WIDTH-1:0] i_async, // raw level
	output logic      [WIDTH-1:0] o_sync   // level after two flops
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta   <= RESET_VAL[WIDTH-1:0];
			o_sync <= RESET_VAL[WIDTH-1:0];
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule

// ==== logic/port_pin_slice.sv ====
// Purpose: pin side of one 8-bit port: input sampling and output drive
// Assumes: direction, latch and address come from the core clock domain
// Notes: drive and enable are registered so the pins never glitch
`timescale 1ns/10ps
`include "gpio_ports_defines.svh"
module port_pin_slice (
	input  wire logic                      i_clk,       // core clock
	input  wire logic                      i_rst_n,     // synchronised reset, active low
	input  wire logic [7:0]                i_pin,       // raw pin levels
	input  wire logic [7:0]                i_direction, // 1 = output
	input  wire logic [7:0]                i_latch,     // output latch
	input  wire logic [7:0]                i_addr_byte, // address byte for this port
	input  gpio_ports_pkg::pin_role_e      i_role,      // pin function of the mode
	input  wire logic                      i_freeze,    // software standby
	input  wire logic                      i_standby,   // hardware standby
	output logic      [7:0]                o_level,     // synchronised pin levels
	output gpio_ports_pkg::pin_drive_s     o_drive      // registered drive and enable
);
	gpio_ports_pkg::pin_drive_s next_drive;

	level_sync #(
		.WIDTH    (8),
		.RESET_VAL(`PIN_LEVEL_RESET)
	) u_pin_sync (
		.i_clk  (i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_pin),
		.o_sync (o_level)
	);

	always_comb begin
		next_drive = o_drive;
		case (i_role)
			gpio_ports_pkg::ROLE_ADDRESS: begin
				next_drive.level  = i_addr_byte;
				next_drive.enable = 8'hff;
			end
			gpio_ports_pkg::ROLE_MIXED: begin
				next_drive.level  = i_addr_byte;
				next_drive.enable = i_direction;
			end
			gpio_ports_pkg::ROLE_GENERAL: begin
				next_drive.level  = i_latch;
				next_drive.enable = i_direction;
			end
			default: begin
				next_drive.level  = i_latch;
				next_drive.enable = 8'h00;
			end
		endcase
		// frozen pins hold whatever they drove when the clock stopped mattering
		if (i_freeze) begin
			next_drive = o_drive;
		end
		// hardware standby floats every pin
		if (i_standby) begin
			next_drive.level  = 8'h00;
			next_drive.enable = 8'h00;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_drive <= '0;
		end else begin
			o_drive <= next_drive;
		end
	end
endmodule

// ==== test/address_gpio_ports_one_two_tb.sv ====
// Purpose: self-checking bench for ports one and two
// Assumes: partner model resolves the pin wires
// Notes: reads queue their expectation, a monitor compares
`timescale 1ns/10ps
module address_gpio_ports_one_two_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  mode = 3'h7;
	logic        hw_n = 1'b1;
	logic        sw = 1'b0;
	logic [15:0] ext = 16'h0000;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wd = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata, pin1, out1, oe1, pin2, out2, oe2, pull2;
	logic [7:0]  val1 = 8'h00;
	logic [7:0]  val2 = 8'h00;
	logic [7:0]  en2 = 8'hff;
	logic [7:0]  expq[$];
	logic        rd_seen = 1'b0;
	int          fail_count = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [7:0]  a, b, d1, d2, pc;
	logic [2:0]  ml[4] = '{3'h1, 3'h3, 3'h5, 3'h6};

	address_gpio_ports_one_two address_gpio_ports_one_two_i (.i_core_clk(clk), .i_resetn(rst_n),
		.i_mode(mode), .i_hw_standby_n(hw_n), .i_sw_standby(sw), .i_ext_addr(ext),
		.i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.i_p1_pin(pin1), .o_p1_out(out1), .o_p1_oe(oe1), .i_p2_pin(pin2), .o_p2_out(out2),
		.o_p2_oe(oe2), .o_p2_pullup(pull2));
	gpio_pin_partner gpio_pin_partner_i (.i_clk(clk), .i_out1(out1), .i_oe1(oe1), .i_out2(out2),
		.i_oe2(oe2), .i_pull2(pull2), .i_val1(val1), .i_val2(val2), .i_en2(en2),
		.o_pin1(pin1), .o_pin2(pin2));

	always #5 clk = ~clk;

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// strobes stay up between calls so back-to-back requests never assign twice
	task automatic wreg(input logic [15:0] ad, input logic [7:0] dt);
		addr <= ad;
		wd <= dt;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rreg(input logic [15:0] ad, input logic [7:0] exp);
		addr <= ad;
		rd <= 1'b1;
		wr <= 1'b0;
		expq.push_back(exp);
		@(posedge clk);
	endtask

	task automatic wait_n(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	task automatic do_reset(input logic [2:0] m);
		rst_n <= 1'b0;
		mode <= m;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		wait_n(15);
	endtask

	always @(posedge clk) begin
		if (rd_seen)
			check(rdata, expq.pop_front());
		rd_seen <= rd;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(5));
		do_reset(3'h7);
		check(oe1, 8'h00);
		check(pull2, 8'h00);
		val1 <= $urandom;
		val2 <= $urandom;
		wait_n(3);
		rreg(16'hffc0, 8'hff);
		rreg(16'hffc1, 8'hff);
		rreg(16'hffc2, val1);
		rreg(16'hffd8, 8'h00);
		rreg(16'hffc5, 8'h00);
		wait_n(2);
		repeat (4) begin
			a = $urandom;
			b = $urandom;
			d1 = $urandom;
			d2 = $urandom;
			pc = $urandom;
			wreg(16'hffc2, a);
			wreg(16'hffc3, b);
			wreg(16'hffc0, d1);
			wreg(16'hffc1, d2);
			wreg(16'hffd8, pc);
			rreg(16'hffd8, pc);
			wreg(16'hffc4, ~a);
			wait_n(5);
			check(oe1, d1);
			check(out1 & d1, a & d1);
			check(out2 & d2, b & d2);
			check(pull2, pc & ~d2);
			rreg(16'hffc2, (d1 & a) | (~d1 & val1));
			rreg(16'hffc3, (d2 & b) | (~d2 & val2));
			rreg(16'hffd8, pc);
			wait_n(2);
		end
		wreg(16'hffc1, 8'h00);
		wreg(16'hffd8, 8'hff);
		en2 <= 8'h00;
		wait_n(5);
		check(pull2, 8'hff);
		rreg(16'hffc3, 8'hff);
		en2 <= 8'hff;
		sw <= 1'b1;
		wreg(16'hffc2, ~a);
		wait_n(4);
		check(out1 & d1, a & d1);
		check(oe1, d1);
		sw <= 1'b0;
		wait_n(2);
		rreg(16'hffc2, (d1 & a) | (~d1 & val1));
		hw_n <= 1'b0;
		wait_n(6);
		check(oe1, 8'h00);
		check(pull2, 8'h00);
		hw_n <= 1'b1;
		wait_n(15);
		rreg(16'hffc2, val1);
		rreg(16'hffd8, 8'h00);
		wreg(16'hffc0, 8'hff);
		wait_n(3);
		rreg(16'hffc2, 8'h00);
		wait_n(2);
		foreach (ml[i]) begin
			do_reset(ml[i]);
			ext <= $urandom;
			wait_n(3);
			if (ml[i] < 3'h5) begin
				check(out1, ext[7:0]);
				check(out2, ext[15:8]);
				wreg(16'hffc0, 8'h0f);
				wreg(16'hffd8, 8'hff);
				wait_n(3);
				check(oe1, 8'hff);
				check(pull2, 8'h00);
				rreg(16'hffc2, 8'h00);
			end else begin
				check(oe1, 8'h00);
				check(oe2, 8'h00);
				d1 = $urandom;
				wreg(16'hffc0, d1);
				wreg(16'hffc1, ~d1);
				wait_n(3);
				check(out1 & d1, ext[7:0] & d1);
				check(oe2, ~d1);
				rreg(16'hffc2, ~d1 & val1);
			end
			wait_n(2);
		end
		print_verdict();
	end
endmodule

bind address_gpio_ports_one_two gpio_ports_properties gpio_ports_properties_i (
	.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_mode(i_mode),
	.i_hw_standby_n(i_hw_standby_n), .i_sw_standby(i_sw_standby), .i_ext_addr(i_ext_addr),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_p1_pin(i_p1_pin), .o_p1_out(o_p1_out),
	.o_p1_oe(o_p1_oe), .i_p2_pin(i_p2_pin), .o_p2_out(o_p2_out), .o_p2_oe(o_p2_oe),
	.o_p2_pullup(o_p2_pullup));

// ==== test/gpio_pin_partner.sv ====
// Purpose: the world outside the pins of ports one and two
// Assumes: the outside drives every pin the port leaves alone, port two may let go
// Notes: a released pin without pull-up toggles so a wrong read shows
`timescale 1ns/10ps
module gpio_pin_partner (
	input  wire logic       i_clk,   // core clock
	input  wire logic [7:0] i_out1,  // port one drive
	input  wire logic [7:0] i_oe1,   // port one enable
	input  wire logic [7:0] i_out2,  // port two drive
	input  wire logic [7:0] i_oe2,   // port two enable
	input  wire logic [7:0] i_pull2, // port two pull-ups
	input  wire logic [7:0] i_val1,  // outside level one
	input  wire logic [7:0] i_val2,  // outside level two
	input  wire logic [7:0] i_en2,   // outside drives port two
	output logic      [7:0] o_pin1,  // wire one
	output logic      [7:0] o_pin2   // wire two
);
	logic [7:0] flt = 8'h5a;

	always @(posedge i_clk)
		flt <= ~flt;
	// outside backs off wherever the port drives
	assign o_pin1 = (i_oe1 & i_out1) | (~i_oe1 & i_val1);
	assign o_pin2 = (i_oe2 & i_out2) | (~i_oe2 & ((i_en2 & i_val2) | (~i_en2 & (i_pull2 | flt))));
endmodule

// ==== test/gpio_ports_properties.sv ====
// Purpose: port one/two checker on the top ports
// Assumes: i_mode only changes while reset is low
// Notes: ok marks 15 quiet cycles after reset or hardware standby
`timescale 1ns/10ps
module gpio_ports_properties (
	input wire logic        i_core_clk,     // clock
	input wire logic        i_resetn,       // reset, active low
	input wire logic [2:0]  i_mode,         // mode straps
	input wire logic        i_hw_standby_n, // hw standby, active low
	input wire logic        i_sw_standby,   // sw standby
	input wire logic [15:0] i_ext_addr,     // bus address
	input wire logic [15:0] i_reg_addr,     // reg address
	input wire logic [7:0]  i_reg_wdata,    // reg data
	input wire logic        i_reg_wr,       // write strobe
	input wire logic        i_reg_rd,       // read strobe
	input wire logic [7:0]  o_reg_rdata,    // read data
	input wire logic [7:0]  i_p1_pin,       // pins one
	input wire logic [7:0]  o_p1_out,       // drive one
	input wire logic [7:0]  o_p1_oe,        // enable one
	input wire logic [7:0]  i_p2_pin,       // pins two
	input wire logic [7:0]  o_p2_out,       // drive two
	input wire logic [7:0]  o_p2_oe,        // enable two
	input wire logic [7:0]  o_p2_pullup     // pull-ups two
);
	logic [3:0] cnt;
	wire        ok = cnt == 4'hf;
	wire        low_modes = i_mode == 3'h1 || i_mode == 3'h3;
	wire        addr_modes = low_modes || i_mode == 3'h5 || i_mode == 3'h6;

	// restart after hw standby, its sync lag would break the timed checks
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			cnt <= 4'h0;
		else if (!i_hw_standby_n)
			cnt <= 4'h0;
		else if (!ok)
			cnt <= cnt + 4'h1;
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_pcr_wr;
		i_reg_wr && i_reg_addr == 16'hffd8 && ok && !i_sw_standby;
	endsequence
	sequence s_pcr_rd;
		i_reg_rd && i_reg_addr == 16'hffd8;
	endsequence

	a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data not idle");
	a_dir_ones: assert property (i_reg_rd && i_reg_addr[15:1] == 15'h7fe0 |=> o_reg_rdata == 8'hff)
		else $error("direction read not all ones");
	a_pcr_back: assert property (s_pcr_wr ##1 s_pcr_rd |=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("pull-up control not read back");
	a_pull_oe: assert property ((o_p2_pullup & o_p2_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	a_hw_quiet: assert property (!i_hw_standby_n [*5] |-> o_p1_oe == 8'h00 && o_p2_oe == 8'h00 && o_p2_pullup == 8'h00)
		else $error("pins active in hw standby");
	a_sw_hold: assert property ($past(i_sw_standby) && i_hw_standby_n |-> $stable(o_p1_out) && $stable(o_p1_oe) && $stable(o_p2_out) && $stable(o_p2_pullup))
		else $error("pins moved in sw standby");
	a_addr_out: assert property (ok && addr_modes && !$past(i_sw_standby) |-> ({o_p2_out, o_p1_out} & {o_p2_oe, o_p1_oe}) == ($past(i_ext_addr) & {o_p2_oe, o_p1_oe}))
		else $error("address pins wrong");
	a_mode_low: assert property (ok && low_modes |-> o_p1_oe == 8'hff && o_p2_oe == 8'hff && o_p2_pullup == 8'h00)
		else $error("address mode pins not driven");
	a_dir_oe: assert property (ok && !i_sw_standby && i_mode >= 3'h5 && i_reg_wr && i_reg_addr == 16'hffc0 |=> ##1 o_p1_oe == $past(i_reg_wdata, 2))
		else $error("enable does not follow direction");
endmodule
